// file: jas_host.sv
module jas_host import jas_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq,
    // Serial port
    jas_if.host port
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;
    state_t st_q;
    logic [1:0] sdo_s;
    logic [15:0] tx_q; // rw, addr, zero, dc, data
    logic [7:0] rx_q;
    logic [4:0] bit_q; // Serial clock cycle index
    logic [2:0] div_q;
    logic sclk_q, cs_n_q;
    logic rw_q;
    logic busy_q;
    logic irq_stat_q, irq_mask_q;
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic start;

    // Sample the device output through two flops
    always_ff @(posedge aclk) begin
        sdo_s <= {sdo_s[0], port.sdo_o};
    end

    // AXI write capture, either channel first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (aw_q && w_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                aw_q <= 1'b0;
                w_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign start = aw_q && w_q && !s_axi_bvalid && awaddr_q == HOST_CMD_OFS && !busy_q;

    // Interrupt status and mask, write one to clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (aw_q && w_q && !s_axi_bvalid && awaddr_q == HOST_IRQ_MASK_OFS) begin
                irq_mask_q <= wdata_q[0];
            end
            if (st_q == ST_DONE) begin
                irq_stat_q <= 1'b1; // Set wins over clear
            end else if (aw_q && w_q && !s_axi_bvalid && awaddr_q == HOST_IRQ_STAT_OFS
                         && wdata_q[0]) begin
                irq_stat_q <= 1'b0;
            end
            irq <= irq_stat_q & irq_mask_q;
        end
    end

    // AXI read path, one cycle latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr)
                HOST_STAT_OFS: s_axi_rdata <= {23'h0, busy_q, rx_q};
                HOST_IRQ_STAT_OFS: s_axi_rdata <= {31'h0, irq_stat_q};
                HOST_IRQ_MASK_OFS: s_axi_rdata <= {31'h0, irq_mask_q};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;

    // Serial frame engine; clock divided from aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            div_q <= 3'h0;
            bit_q <= 5'h00;
            tx_q <= 16'h0;
            rx_q <= 8'h00;
            rw_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        // wdata: [8] read, [4:0] address, [23:16] data
                        rw_q <= wdata_q[8];
                        tx_q <= {wdata_q[23:16], 2'b00, wdata_q[4:0], wdata_q[8]};
                        cs_n_q <= 1'b0;
                        busy_q <= 1'b1;
                        div_q <= 3'h0;
                        bit_q <= 5'h00;
                        st_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Select leads the first clock edge by a full period
                    div_q <= div_q + 3'h1;
                    if (div_q == 3'(SCLK_HALF_CYC - 1)) begin
                        div_q <= 3'h0;
                        st_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    div_q <= div_q + 3'h1;
                    if (div_q == 3'(SCLK_HALF_CYC - 1)) begin
                        div_q <= 3'h0;
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            // Falling edge: next bit out, LSB first
                            // Plain shift also lines the data up for cycle 9
                            tx_q <= {1'b0, tx_q[15:1]};
                            // Take the bit at the end of its high phase, since
                            // the returned bit lags several clocks behind the edge
                            if (rw_q && bit_q >= DATA_FIRST_CYCLE) begin
                                rx_q <= {sdo_s[1], rx_q[7:1]};
                            end
                            if (bit_q == DATA_LAST_CYCLE) begin
                                st_q <= ST_DONE;
                            end
                        end else begin
                            bit_q <= bit_q + 5'h01;
                        end
                    end
                end
                ST_DONE: begin
                    cs_n_q <= 1'b1;
                    busy_q <= 1'b0;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign port.sclk = sclk_q;
    assign port.cs_n = cs_n_q;
    // Loaded at select, then changes only on falling edges; bits 7 and 8 are zeros in the frame word
    assign port.serial_data_in = tx_q[0];
endmodule : jas_host

// file: jas_pkg.sv
package jas_pkg;
    // Register addresses on the serial port
    localparam logic [4:0] CHAN0_CONFIG_ADDR = 5'h06;
    localparam logic [4:0] CHAN0_FIFO_FLAG_ADDR = 5'h07;
    localparam logic [4:0] CHAN1_CONFIG_ADDR = 5'h0E;
    localparam logic [4:0] CHAN1_FIFO_FLAG_ADDR = 5'h0F;
    localparam logic [4:0] CHAN2_CONFIG_ADDR = 5'h16;
    localparam logic [4:0] CHAN2_FIFO_FLAG_ADDR = 5'h17;
    // Config field positions
    localparam int FSS_BIT = 0;
    localparam int CLK_EDGE_BIT = 1;
    localparam int BW_BIT = 2;
    localparam int ATT_DIS_BIT = 3;
    localparam int RATE_BIT = 4;
    localparam int SONET_BIT = 5;
    localparam logic [7:0] CONFIG_MASK = 8'h3F;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // Frame layout in serial clock cycles
    localparam logic [4:0] ADDR_LAST_CYCLE = 5'h06;
    localparam logic [4:0] DATA_FIRST_CYCLE = 5'h09;
    localparam logic [4:0] DATA_LAST_CYCLE = 5'h10;
    // Host timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CS_SETUP_NS = 50;
    localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = 4;
    // Host controller register offsets
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam logic [7:0] HOST_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] HOST_IRQ_MASK_OFS = 8'h0C;
    // Channel address to config register address
    function automatic logic [4:0] chan_addr(input logic [1:0] ch);
        chan_addr = {ch, 3'h6};
    endfunction : chan_addr
endpackage : jas_pkg

// file: jas_if.sv
interface jas_if;
    logic sclk;
    logic cs_n;
    logic serial_data_in;
    logic sdo_o;
    logic sdo_oe;
    // Device end of the serial port
    modport device (input sclk, input cs_n, input serial_data_in, output sdo_o, output sdo_oe);
    // Host end of the serial port
    modport host (output sclk, output cs_n, output serial_data_in, input sdo_o, input sdo_oe);
endinterface : jas_if

// file: jas_device.sv
module jas_device import jas_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Serial port
    jas_if.device port,
    // Straps and hardware-mode pins
    input wire logic mode_strap,
    input wire logic clock_edge_select,
    input wire logic fifo_size_select,
    input wire logic bandwidth_select,
    input wire logic attenuator_disable,
    input wire logic line_rate_select,
    input wire logic channel_sel_lo,
    input wire logic channel_sel_hi,
    // FIFO limit flag from the datapath
    input wire logic fifo_limit_flag,
    // Active configuration
    output logic [5:0] config_out
);
    // Synchronisers for the serial pins and straps
    logic [1:0] sclk_s, cs_s, sdi_s, mode_s;
    logic [1:0] chan_s0, chan_s1, flag_s;
    logic [4:0] hw_s0, hw_s1;
    logic sclk_prev_q;
    logic rise, fall;
    // Frame state
    logic [4:0] cyc_q;
    logic rd_q;
    logic [4:0] addr_q;
    logic [7:0] sh_q;
    logic [7:0] rdata_q;
    logic sdo_q, oe_q;
    logic [7:0] cfg_q [3];
    logic [1:0] ch;
    logic [7:0] rd_word;

    // Two flops on every outside input
    always_ff @(posedge aclk) begin
        sclk_s <= {sclk_s[0], port.sclk};
        cs_s <= {cs_s[0], port.cs_n};
        sdi_s <= {sdi_s[0], port.serial_data_in};
        mode_s <= {mode_s[0], mode_strap};
        chan_s0 <= {chan_s0[0], channel_sel_lo};
        chan_s1 <= {chan_s1[0], channel_sel_hi};
        flag_s <= {flag_s[0], fifo_limit_flag};
        hw_s0 <= {line_rate_select, attenuator_disable, bandwidth_select,
                  clock_edge_select, fifo_size_select};
        hw_s1 <= hw_s0;
    end

    // Edge detect on the synchronised serial clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s[1];
        end
    end
    assign rise = sclk_s[1] & ~sclk_prev_q & ~cs_s[1] & mode_s[1];
    assign fall = ~sclk_s[1] & sclk_prev_q & ~cs_s[1] & mode_s[1];

    // Selected channel of this device
    assign ch = addr_q[4:3];

    // Read word: config or flag by low address bit
    always_comb begin
        rd_word = 8'h00;
        if (addr_q[2:1] == 2'b11 && addr_q[4:3] != 2'b11) begin
            if (addr_q[0]) begin
                rd_word = {7'h00, flag_s[1]};
            end else begin
                rd_word = cfg_q[ch] & CONFIG_MASK;
            end
        end
    end

    // Bit counter and header capture on rising edges
    always_ff @(posedge aclk) begin
        if (!aresetn || cs_s[1] || !mode_s[1]) begin
            cyc_q <= 5'h00;
            rd_q <= 1'b0;
            addr_q <= 5'h00;
            sh_q <= 8'h00;
        end else if (rise) begin
            cyc_q <= cyc_q + 5'h01;
            if (cyc_q == 5'h00) begin
                rd_q <= sdi_s[1];
            end else if (cyc_q <= ADDR_LAST_CYCLE - 5'h01) begin
                addr_q <= {sdi_s[1], addr_q[4:1]};
            end else if (cyc_q >= DATA_FIRST_CYCLE - 5'h01 && cyc_q < DATA_LAST_CYCLE) begin
                sh_q <= {sdi_s[1], sh_q[7:1]};
            end
            // Bits 7 and 8 are skipped: fixed zero and don't care
        end
    end

    // Config registers: commit after the eighth data bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                cfg_q[i] <= CONFIG_RESET;
            end
        end else if (rise && !rd_q && cyc_q == DATA_LAST_CYCLE - 5'h01
                     && addr_q[2:0] == 3'h6 && addr_q[4:3] != 2'b11) begin
            cfg_q[ch] <= {sdi_s[1], sh_q[7:1]} & CONFIG_MASK;
        end
    end

    // Read shifter on falling edges, output tri-stated otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn || cs_s[1] || !mode_s[1]) begin
            oe_q <= 1'b0;
            sdo_q <= 1'b0;
            rdata_q <= 8'h00;
        end else if (fall && rd_q) begin
            if (cyc_q == DATA_FIRST_CYCLE - 5'h01) begin
                oe_q <= 1'b1;
                sdo_q <= rd_word[0];
                rdata_q <= {1'b0, rd_word[7:1]};
            end else if (cyc_q >= DATA_FIRST_CYCLE && cyc_q < DATA_LAST_CYCLE) begin
                sdo_q <= rdata_q[0];
                rdata_q <= {1'b0, rdata_q[7:1]};
            end else if (cyc_q >= DATA_LAST_CYCLE) begin
                oe_q <= 1'b0;
            end
        end
    end
    assign port.sdo_o = sdo_q;
    assign port.sdo_oe = oe_q;

    // Active configuration: pins or serial register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_out <= 6'h00;
        end else if (!mode_s[1]) begin
            config_out <= {1'b0, hw_s1[4:3], hw_s1[2], hw_s1[1], hw_s1[0]};
        end else begin
            // Channel pins pick which register applies
            config_out <= cfg_q[(chan_s1[1] & ~chan_s0[1]) ? 2'd2
                                : {1'b0, chan_s0[1] & ~chan_s1[1]}][5:0];
        end
    end
endmodule : jas_device

// file: jas_monitor.sv
module jas_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Serial port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk_q; // Last clock level
    logic [4:0] rises_q; // Rising edges in frame
    logic rw_q; // Direction of frame
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Edge count, idle frames clear it
    always_ff @(posedge aclk) begin
        sclk_q <= sclk;
        if (!aresetn || cs_n)
            rises_q <= 5'h00;
        else if (sclk && !sclk_q)
            rises_q <= rises_q + 5'h01;
    end
    // Direction taken at first rise
    always_ff @(posedge aclk)
        if (sclk && !sclk_q && !cs_n && rises_q == 5'h00)
            rw_q <= serial_data_in;
    property p_cs_setup; $fell(cs_n) |-> !sclk; endproperty
    a_cs_setup: assert property (p_cs_setup) else $error("clock high at select");
    property p_oe_read; sdo_oe |-> rw_q; endproperty
    a_oe_read: assert property (p_oe_read) else $error("output on in write");
    property p_sdi_steady; $rose(sclk) && !cs_n |-> $stable(serial_data_in); endproperty
    a_sdi_steady: assert property (p_sdi_steady) else $error("input moved at rise");
    property p_zero_bit; $rose(sclk) && !cs_n && rises_q == 5'h06 |-> !serial_data_in; endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("seventh bit not zero");
    property p_oe_start; $rose(sdo_oe) |-> rises_q == 5'h08 && !sclk; endproperty
    a_oe_start: assert property (p_oe_start) else $error("output on early or late");
    property p_sdo_steady; $rose(sclk) && sdo_oe |-> $stable(sdo_o); endproperty
    a_sdo_steady: assert property (p_sdo_steady) else $error("output moved at rise");
    property p_frame_len; $rose(cs_n) |-> rises_q == 5'h10; endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not sixteen bits");
    property p_oe_off; $rose(cs_n) |-> ##[0:4] !sdo_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output left on");
    // Main traffic seen
    c_read: cover property ($rose(sdo_oe));
    c_write: cover property ($rose(cs_n) && !rw_q);
    c_start: cover property ($fell(cs_n));
endmodule : jas_monitor

// file: tb.sv
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb import jas_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    // Register bus, idle at start
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    // Straps and device pins
    logic mode_strap = 1'b1, clock_edge_select = 1'b0, fifo_size_select = 1'b0;
    logic bandwidth_select = 1'b0, attenuator_disable = 1'b0, line_rate_select = 1'b0;
    logic channel_sel_lo = 1'b0, channel_sel_hi = 1'b0, fifo_limit_flag = 1'b0;
    logic [5:0] config_out;
    int n_mismatch = 0, checks = 0, cyc = 0;
    logic [15:0] frm; // Input bits, first at bit 0
    logic [7:0] cap; // Output bits, first at bit 0
    logic oe_seen = 1'b0; // Device drove the line
    jas_if bus();
    jas_device jas_device_i (.aclk, .aresetn, .port(bus.device), .mode_strap,
        .clock_edge_select, .fifo_size_select, .bandwidth_select, .attenuator_disable,
        .line_rate_select, .channel_sel_lo, .channel_sel_hi, .fifo_limit_flag, .config_out);
    jas_host jas_host_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .port(bus.host));
    jas_monitor jas_monitor_i (.aclk, .aresetn, .sclk(bus.sclk), .cs_n(bus.cs_n),
        .serial_data_in(bus.serial_data_in), .sdo_o(bus.sdo_o), .sdo_oe(bus.sdo_oe));
    always #50 aclk = ~aclk;
    // Wire watchers, shift on serial rises
    always @(posedge bus.sclk) if (!bus.cs_n) frm = {bus.serial_data_in, frm[15:1]};
    always @(posedge bus.sclk) if (bus.sdo_oe) cap = {bus.sdo_o, cap[7:1]};
    always @(posedge aclk) if (bus.sdo_oe) oe_seen = 1'b1;
    // Hang guard, well above the expected run
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // Write: both channels offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        logic r;
        r = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            r = s_axi_rvalid;
            d = s_axi_rdata;
        end
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // One serial frame; polls busy, checks what crossed the wire
    task automatic ser(input logic rw, input logic [4:0] a, input logic [7:0] d,
            output logic [7:0] q);
        logic [31:0] s;
        axi_wr(HOST_CMD_OFS, {8'h00, d, 7'h00, rw, 3'h0, a});
        s = 32'h100;
        while (s[8]) axi_rd(HOST_STAT_OFS, s);
        q = s[7:0];
        `CHK(frm[0], rw, "direction bit")
        `CHK(frm[5:1], a, "address bits")
        `CHK(frm[6], 1'b0, "fixed bit")
        if (!rw) `CHK(frm[15:8], d, "write bits")
    endtask : ser
    task automatic t_reset;
        logic [7:0] q;
        ser(1'b1, 5'h06, 8'h00, q);
        `CHK(q, CONFIG_RESET, "config after reset")
        `CHK(irq, 1'b0, "irq after reset")
    endtask : t_reset
    // All channels written, then read back; top bits never stick
    task automatic t_config;
        logic [7:0] q;
        for (int c = 0; c < 3; c++) ser(1'b0, {c[1:0], 3'h6}, {2'b11, c[1:0], ~c[1:0], c[1:0]}, q);
        for (int c = 0; c < 3; c++) begin
            ser(1'b1, {c[1:0], 3'h6}, 8'h00, q);
            `CHK(q, {2'b00, c[1:0], ~c[1:0], c[1:0]}, "config read")
            `CHK(cap, q, "line bits")
            {channel_sel_hi, channel_sel_lo} <= c[1:0];
            repeat (4) @(posedge aclk);
            `CHK(config_out, {c[1:0], ~c[1:0], c[1:0]}, "active config")
        end
        ser(1'b1, 5'h1E, 8'h00, q);
        `CHK(q, 8'h00, "unmapped channel")
    endtask : t_config
    // Status follows the flag; writes to it change nothing
    task automatic t_status;
        logic [7:0] q;
        fifo_limit_flag <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            ser(1'b1, {c[1:0], 3'h7}, 8'h00, q);
            `CHK(q, 8'h01, "flag set")
        end
        fifo_limit_flag <= 1'b0;
        ser(1'b0, 5'h07, 8'hFF, q);
        ser(1'b1, 5'h07, 8'h00, q);
        `CHK(q, 8'h00, "status write ignored")
    endtask : t_status
    // Strap low: pins rule, serial traffic has no effect
    task automatic t_hw;
        logic [7:0] q;
        logic [4:0] p;
        mode_strap <= 1'b0;
        oe_seen = 1'b0;
        for (int i = 0; i < 2; i++) begin
            p = i ? 5'b01010 : 5'b10101;
            {line_rate_select, attenuator_disable, bandwidth_select} <= p[4:2];
            {clock_edge_select, fifo_size_select} <= p[1:0];
            channel_sel_lo <= i[0];
            repeat (4) @(posedge aclk);
            `CHK({config_out[RATE_BIT], config_out[ATT_DIS_BIT], config_out[BW_BIT],
                config_out[CLK_EDGE_BIT], config_out[FSS_BIT]}, p, "pin config")
        end
        ser(1'b0, 5'h06, 8'h2A, q);
        ser(1'b1, 5'h06, 8'h00, q);
        `CHK(oe_seen, 1'b0, "output in pin mode")
        mode_strap <= 1'b1;
        repeat (4) @(posedge aclk);
        ser(1'b1, 5'h06, 8'h00, q);
        `CHK(q, 8'h0C, "config kept")
        `CHK(oe_seen, 1'b1, "output in host mode")
    endtask : t_hw
    // Frame done: masked, unmasked, cleared
    task automatic t_irq;
        logic [7:0] q;
        logic [31:0] s;
        axi_wr(HOST_IRQ_MASK_OFS, 32'h0);
        axi_wr(HOST_IRQ_STAT_OFS, 32'h1);
        ser(1'b1, 5'h0E, 8'h00, q);
        axi_rd(HOST_IRQ_STAT_OFS, s);
        `CHK(s[0], 1'b1, "done sticky")
        `CHK(irq, 1'b0, "masked irq")
        axi_wr(HOST_IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1, "unmasked irq")
        axi_wr(HOST_IRQ_STAT_OFS, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0, "cleared irq")
        axi_rd(8'h10, s);
        `CHK(s, 32'h0, "unmapped host register")
    endtask : t_irq
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_config;
        t_status;
        t_hw;
        t_irq;
        tally_and_finish;
    end
endmodule : tb
